/* core/esdr_pkg.sv */
// Purpose: Shared constants for the slot decode and refresh block
// Assumes: One clock, synchronous active-low reset
// Notes:   Mode field encodings are local choices
package esdr_pkg;
  localparam logic [1:0] MODE_ENCODED = 2'h0;
  localparam logic [1:0] MODE_DIRECT  = 2'h1;
  localparam logic [3:0] SLOT_NONE    = 4'hF;
  localparam logic [3:0] SLOT_ZERO    = 4'h0;
  localparam logic [3:0] GRANT_NONE   = 4'hF;
  localparam logic [3:0] DIR_NONE     = 4'hF;
  localparam logic [3:0] DIR_ALL      = 4'h0;
  localparam logic [3:0] ENC_MAX_SLOT = 4'h8;
  localparam logic [3:0] DIR_MAX_SLOT = 4'h4;
  localparam logic [3:0] ENC_MAX_MST  = 4'h7;
  localparam logic [3:0] DIR_MAX_MST  = 4'h3;
  localparam logic [3:0] BE_ALL       = 4'hF;
  localparam int         LA_LO_W      = 14;
  localparam int         PAGE_W       = 8;

  typedef enum logic [1:0] {
    ESDR_DMA_COMPAT = 2'h0,
    ESDR_DMA_TYPE_A = 2'h1,
    ESDR_DMA_TYPE_B = 2'h2,
    ESDR_DMA_TYPE_C = 2'h3
  } esdr_timing_e;
endpackage

/* core/esdr_refresh_fsm.sv */
// Purpose: Refresh cycle sequencer with ready stretching
// Assumes: Requests are single-cycle pulses or levels
// Notes:   Cycle length is a parameter in clocks
`timescale 1ns/1ps
module esdr_refresh_fsm #(
  parameter int CYC_CLKS = 4
) (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic start_i,
  input  wire logic ready_i,
  output logic      busy_o,
  output logic      done_o
);
  typedef enum logic [2:0] {
    ESDR_RF_IDLE = 3'b001,
    ESDR_RF_RUN  = 3'b010,
    ESDR_RF_WAIT = 3'b100
  } esdr_rf_e;

  esdr_rf_e   state_r;
  logic [7:0] cnt_r;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_r <= ESDR_RF_IDLE;
      cnt_r   <= 8'h00;
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_r)
        ESDR_RF_IDLE: begin
          if (start_i) begin
            state_r <= ESDR_RF_RUN;
            cnt_r   <= 8'(CYC_CLKS - 1);
            busy_o  <= 1'b1;
          end
        end
        ESDR_RF_RUN: begin
          if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            state_r <= ESDR_RF_WAIT;
          end
        end
        ESDR_RF_WAIT: begin
          if (ready_i) begin // Slow slave stretches here
            state_r <= ESDR_RF_IDLE;
            busy_o  <= 1'b0;
            done_o  <= 1'b1;
          end
        end
        default: begin
          state_r <= ESDR_RF_IDLE;
          busy_o  <= 1'b0;
        end
      endcase
    end
  end

  chk_ready_stretch: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    (state_r == ESDR_RF_WAIT && !ready_i) |=> busy_o)
    else $error("Refresh ended while not ready");
endmodule // esdr_refresh_fsm

/* core/esdr_top.sv */
// Purpose: Slot enables, master grants, refresh drive, DMA timing select
// Assumes: Inputs synchronous to clk_sys_i
// Notes:   Mode select is a plain input, no register bus
// Summary of operation
// - EISA-resident memory lets DMA use type A, B or C timing
// - ISA-resident memory forces compatible DMA timing
// - Refresh indicator held low for whole refresh cycle
// - Refresh started by internal unit or external ISA master
// - Refresh drives low address lines 15:2 and all byte enables
// - Refresh drives page registers onto upper address lines
// - Ready line negation extends internal refresh until it returns
// - Encoded slot enables and grants for eight slots by default
// - Two-bit mode field selects direct four-slot outputs
// - Direct mode IO nibble 1..4 drives matching slot enable low
// - Encoded mode IO nibble 1..8 output binary, else ones or zeros
// - No reserved encoded slot enable value is produced
// - Direct mode drives discrete active-low grants for masters 0-3
// - Encoded grant 0..7 selects master, ones means none
// - Encoded grant values 8 to 14 never driven
`timescale 1ns/1ps
module esdr_top #(
  parameter int REF_CLKS = 4
) (
  input  wire logic        clk_sys_i,
  input  wire logic        nrst_i,
  input  wire logic [1:0]  mode_sel_i,
  input  wire logic        cyc_io_i,
  input  wire logic        cyc_dma_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        grant_vld_i,
  input  wire logic [2:0]  grant_id_i,
  input  wire logic        mem_eisa_i,
  input  wire logic [1:0]  dma_req_timing_i,
  input  wire logic        ref_int_req_i,
  input  wire logic        ref_ext_i,
  input  wire logic        ready_i,
  input  wire logic [13:0] ref_row_i,
  input  wire logic [7:0]  page_hi_i,
  input  wire logic [7:0]  page_lo_i,
  output logic [3:0]       slot_en_o,
  output logic [3:0]       grant_o,
  output logic [1:0]       dma_timing_o,
  output logic             refresh_n_o,
  output logic [13:0]      la_lo_o,
  output logic             la_lo_oe_o,
  output logic [15:0]      la_hi_o,
  output logic             la_hi_oe_o,
  output logic [3:0]       be_n_o,
  output logic             be_oe_o,
  output logic             data_oe_o
);
  logic rf_busy;
  logic rf_done;
  logic direct;
  logic [3:0] slot_nxt;
  logic [3:0] grant_nxt;
  logic [3:0] nib;

  assign direct = (mode_sel_i == esdr_pkg::MODE_DIRECT);
  assign nib    = addr_i[15:12];

  esdr_refresh_fsm #(
    .CYC_CLKS (REF_CLKS)
  ) u_rf (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .start_i   (ref_int_req_i && !ref_ext_i),
    .ready_i   (ready_i),
    .busy_o    (rf_busy),
    .done_o    (rf_done)
  );

  always_comb begin
    slot_nxt = esdr_pkg::SLOT_ZERO;
    if (cyc_dma_i) begin
      slot_nxt = esdr_pkg::SLOT_NONE;
    end else if (cyc_io_i && addr_i[9:8] == 2'h0) begin
      if (direct) begin
        slot_nxt = esdr_pkg::DIR_NONE;
        if (nib != 4'h0 && nib <= esdr_pkg::DIR_MAX_SLOT) begin
          slot_nxt[nib[1:0] - 2'h1] = 1'b0;
        end
      end else if (nib != 4'h0 && nib <= esdr_pkg::ENC_MAX_SLOT) begin
        slot_nxt = nib;
      end else begin
        slot_nxt = esdr_pkg::SLOT_NONE;
      end
    end
  end

  always_comb begin
    grant_nxt = esdr_pkg::GRANT_NONE;
    if (grant_vld_i) begin
      if (direct) begin
        if ({1'b0, grant_id_i} <= esdr_pkg::DIR_MAX_MST) begin
          grant_nxt[grant_id_i[1:0]] = 1'b0;
        end
      end else begin
        grant_nxt = {1'b0, grant_id_i};
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      slot_en_o <= esdr_pkg::SLOT_ZERO;
      grant_o   <= esdr_pkg::GRANT_NONE;
    end else begin
      slot_en_o <= slot_nxt;
      grant_o   <= grant_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      dma_timing_o <= esdr_pkg::ESDR_DMA_COMPAT;
    end else if (mem_eisa_i) begin
      dma_timing_o <= dma_req_timing_i;
    end else begin
      dma_timing_o <= esdr_pkg::ESDR_DMA_COMPAT;
    end
  end

  // Either refresh source gets our address drive; data never driven
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      refresh_n_o <= 1'b1;
      la_lo_o     <= '0;
      la_lo_oe_o  <= 1'b0;
      la_hi_o     <= 16'h0000;
      la_hi_oe_o  <= 1'b0;
      be_n_o      <= esdr_pkg::BE_ALL;
      be_oe_o     <= 1'b0;
      data_oe_o   <= 1'b0;
    end else begin
      refresh_n_o <= !(rf_busy || ref_ext_i);
      la_lo_oe_o  <= rf_busy || ref_ext_i;
      be_oe_o     <= rf_busy || ref_ext_i;
      la_lo_o     <= ref_row_i;
      be_n_o      <= ~esdr_pkg::BE_ALL;
      la_hi_oe_o  <= rf_busy || ref_ext_i;
      la_hi_o     <= {page_hi_i, page_lo_i};
      data_oe_o   <= 1'b0; // Never drive data in refresh
    end
  end

  chk_enc_slot_legal: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    !direct |=> (slot_en_o <= esdr_pkg::ENC_MAX_SLOT
    || slot_en_o == esdr_pkg::SLOT_NONE))
    else $error("Reserved encoded slot value");
  chk_enc_grant_legal: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    !direct |=> (grant_o <= esdr_pkg::ENC_MAX_MST
    || grant_o == esdr_pkg::GRANT_NONE))
    else $error("Reserved encoded grant value");
  chk_isa_compat: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    !mem_eisa_i |=> dma_timing_o == esdr_pkg::ESDR_DMA_COMPAT)
    else $error("ISA memory with fast DMA timing");
  chk_eisa_timing: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    mem_eisa_i |=> dma_timing_o == $past(dma_req_timing_i))
    else $error("EISA timing not taken");
  chk_refresh_flag: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    rf_busy |=> !refresh_n_o && la_lo_oe_o && be_oe_o)
    else $error("Refresh flag or drivers missing");
  chk_ext_refresh: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    ref_ext_i |=> !refresh_n_o && la_hi_oe_o)
    else $error("External refresh not flagged");
  chk_refresh_end: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    (!rf_busy && !ref_ext_i) |=> refresh_n_o && !la_lo_oe_o && !be_oe_o)
    else $error("Refresh flag left on");
  chk_page_drive: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    rf_busy |=> la_hi_o == {$past(page_hi_i), $past(page_lo_i)})
    else $error("Page bits not on upper address");
  chk_low_drive: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    rf_busy |=> la_lo_o == $past(ref_row_i) && be_n_o == 4'h0)
    else $error("Low address or byte enables wrong");
  chk_data_off: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    (rf_busy || ref_ext_i) |=> !data_oe_o)
    else $error("Data driven during refresh");
  chk_dir_slot: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    (direct && !cyc_dma_i && cyc_io_i && addr_i[9:8] == 2'h0
    && addr_i[15:12] == 4'h3) |=> slot_en_o == 4'hB)
    else $error("Direct slot three wrong");
  chk_dir_dma_high: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    (direct && cyc_dma_i) |=> slot_en_o == esdr_pkg::DIR_NONE)
    else $error("Direct DMA slot enables not high");
  chk_enc_io_slot: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    (!direct && !cyc_dma_i && cyc_io_i && addr_i[9:8] == 2'h0
    && nib != 4'h0 && nib <= esdr_pkg::ENC_MAX_SLOT)
    |=> slot_en_o == $past(nib))
    else $error("Encoded slot number wrong");
  chk_mem_zero: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    (!cyc_dma_i && !cyc_io_i) |=> slot_en_o == 4'h0)
    else $error("Memory cycle slot enables not low");
  chk_dir_grant: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    (direct && grant_vld_i && grant_id_i == 3'h2)
    |=> grant_o == 4'hB)
    else $error("Direct grant two wrong");
  chk_enc_grant_id: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    (!direct && grant_vld_i) |=> grant_o == {1'b0, $past(grant_id_i)})
    else $error("Encoded grant number wrong");
  chk_grant_idle: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    !grant_vld_i |=> grant_o == esdr_pkg::GRANT_NONE)
    else $error("Grant shown with no master");

  cov_refresh_done: cover property (@(posedge clk_sys_i) rf_done);
  cov_ext_refresh: cover property (@(posedge clk_sys_i) ref_ext_i);
  cov_enc_slot8: cover property (@(posedge clk_sys_i) slot_en_o == 4'h8);
  cov_stretch: cover property (@(posedge clk_sys_i)
    (rf_busy && !ready_i) [*3]);
  cov_dir_grant3: cover property (@(posedge clk_sys_i)
    direct && grant_o == 4'h7);
endmodule // esdr_top

/* verif/esdr_slot_model.sv */
// Purpose: Slot card side, slow memory slave and board decoder
// Assumes: Encoded slot enables, refresh indicator active low
// Notes:   Slow mode holds ready low for 8 refresh clocks
`timescale 1ns/1ps
module esdr_slot_model (
  input  wire logic       clk_sys_i,
  input  wire logic       refresh_n_i,
  input  wire logic       slow_i,
  input  wire logic [3:0] slot_en_i,
  output logic            ready_o,
  output logic [7:0]      slot_n_o
);
  logic [3:0] wait_r;
  // Counts refresh clocks so stretching ends on its own
  always_ff @(posedge clk_sys_i) begin
    if (refresh_n_i) wait_r <= 4'h0;
    else if (wait_r != 4'h8) wait_r <= wait_r + 4'h1;
  end
  assign ready_o = !(slow_i && !refresh_n_i && wait_r != 4'h8);
  // No data drivers exist here, so refresh never sees data
  always_comb begin
    slot_n_o = 8'hFF;
    if (slot_en_i >= 4'h1 && slot_en_i <= 4'h8) begin
      slot_n_o[slot_en_i - 4'h1] = 1'b0;
    end
  end
endmodule // esdr_slot_model

/* verif/test_eisa_slot_decode_refresh.sv */
// Purpose: Self-checking bench for slot decode and refresh
// Assumes: Outputs update one clock after inputs
// Notes:   Expected values worked out here, not read back
`timescale 1ns/1ps
module test_eisa_slot_decode_refresh;
  logic clk_sys_i = 0, nrst_i = 0, cyc_io_i = 0, cyc_dma_i = 0, slow = 0;
  logic grant_vld_i = 0, mem_eisa_i = 0, ref_int_req_i = 0, ref_ext_i = 0;
  logic [1:0] mode_sel_i = 0, dma_req_timing_i = 0, dma_timing_o;
  logic [2:0] grant_id_i = 0;
  logic [15:0] addr_i = 0, la_hi_o;
  logic [13:0] ref_row_i = 0, la_lo_o;
  logic [7:0] page_hi_i = 0, page_lo_i = 0, slot_n;
  logic [3:0] slot_en_o, grant_o, be_n_o;
  logic ready_i, refresh_n_o, la_lo_oe_o, la_hi_oe_o, be_oe_o, data_oe_o;
  int num_errors = 0, check_count = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  esdr_top #(.REF_CLKS(4)) i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .mode_sel_i(mode_sel_i), .cyc_io_i(cyc_io_i), .cyc_dma_i(cyc_dma_i),
    .addr_i(addr_i), .grant_vld_i(grant_vld_i), .grant_id_i(grant_id_i),
    .mem_eisa_i(mem_eisa_i), .dma_req_timing_i(dma_req_timing_i),
    .ref_int_req_i(ref_int_req_i), .ref_ext_i(ref_ext_i), .ready_i(ready_i),
    .ref_row_i(ref_row_i), .page_hi_i(page_hi_i), .page_lo_i(page_lo_i),
    .slot_en_o(slot_en_o), .grant_o(grant_o), .dma_timing_o(dma_timing_o),
    .refresh_n_o(refresh_n_o), .la_lo_o(la_lo_o), .la_lo_oe_o(la_lo_oe_o),
    .la_hi_o(la_hi_o), .la_hi_oe_o(la_hi_oe_o), .be_n_o(be_n_o),
    .be_oe_o(be_oe_o), .data_oe_o(data_oe_o));
  esdr_slot_model i_slots (.clk_sys_i(clk_sys_i), .refresh_n_i(refresh_n_o),
    .slow_i(slow), .slot_en_i(slot_en_o), .ready_o(ready_i),
    .slot_n_o(slot_n));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Every cycle kind, nibble and grant id in one mode
  task automatic t_decode(input logic [1:0] m);
    logic dir;
    logic [1:0] k;
    logic [3:0] n, e, g;
    logic [7:0] d;
    dir = (m == esdr_pkg::MODE_DIRECT);
    for (int c = 0; c < 64; c++) begin
      n = c[3:0];
      k = c[5:4];
      @(posedge clk_sys_i);
      mode_sel_i <= m;
      cyc_io_i <= (k < 2'h2);
      cyc_dma_i <= (k == 2'h2);
      addr_i <= {n, 2'h3, (k == 2'h1) ? (n[1:0] | 2'h1) : 2'h0, 8'h5A};
      grant_vld_i <= c[4];
      grant_id_i <= c[2:0];
      mem_eisa_i <= c[0];
      dma_req_timing_i <= c[2:1];
      @(posedge clk_sys_i);
      #1;
      if (k == 2'h2) e = 4'hF;
      else if (k != 2'h0) e = 4'h0;
      else if (dir) e = (n >= 1 && n <= 4) ? ~(4'h1 << (n - 1)) : 4'hF;
      else e = (n >= 1 && n <= 8) ? n : 4'hF;
      if (!c[4]) g = 4'hF;
      else if (dir) g = (c[2] == 0) ? ~(4'h1 << c[1:0]) : 4'hF;
      else g = {1'b0, c[2:0]};
      check(slot_en_o, e);
      check(grant_o, g);
      check(dma_timing_o, c[0] ? c[2:1] : 2'h0);
      d = (e >= 4'h1 && e <= 4'h8) ? ~(8'h01 << (e - 4'h1)) : 8'hFF;
      if (!dir) check(slot_n, d);
    end
  endtask
  // Internal or external refresh, optionally stretched by a slow slave
  task automatic t_refresh(input logic slw, input logic ext);
    int len;
    @(posedge clk_sys_i);
    slow <= slw;
    ref_int_req_i <= !ext;
    ref_ext_i <= ext;
    page_hi_i <= 8'hC3;
    page_lo_i <= 8'h3C;
    ref_row_i <= 14'h2A55;
    @(posedge clk_sys_i);
    ref_int_req_i <= 1'b0;
    #1;
    len = 0;
    while (refresh_n_o !== 1'b0 && len < 4) begin
      @(posedge clk_sys_i);
      #1;
      len++;
    end
    len = 0;
    while (refresh_n_o === 1'b0 && len < 40) begin
      check({la_lo_oe_o, la_hi_oe_o, be_oe_o, be_n_o}, 7'h70);
      check(data_oe_o, 1'b0);
      check(la_hi_o, 16'hC33C);
      check(la_lo_o, 14'h2A55);
      len++;
      @(posedge clk_sys_i);
      if (ext && len == 10) ref_ext_i <= 1'b0;
      #1;
    end
    check(16'(len), slw ? 16'hA : ext ? 16'hB : 16'h5);
    check({refresh_n_o, la_hi_oe_o, be_oe_o, be_n_o}, 7'h40);
    check({la_lo_oe_o, data_oe_o}, 2'h0);
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    check({refresh_n_o, dma_timing_o, slot_en_o, grant_o}, 11'h40F);
    t_decode(2'h0);
    t_decode(esdr_pkg::MODE_DIRECT);
    t_decode(2'h3);
    t_refresh(1'b0, 1'b0);
    t_refresh(1'b1, 1'b0);
    t_refresh(1'b0, 1'b1);
    final_report();
  end
  initial begin
    #20000;
    num_errors++;
    final_report();
  end
endmodule // test_eisa_slot_decode_refresh
